// file: rtl/oc_pkg.sv
/*
 * Constants for the oscillator output control block: register offsets,
 * field positions, reset values, clock source codes and output states.
 * Assumes a 100 MHz APB clock and 32-bit APB data with byte addresses.
 */
// Summary of operation
// [RULE_01] Module runs only while the enable bit is one.
// [RULE_02] Output pin is driven only while the pin enable bit is one.
// [RULE_03] Read-only status bit shows the current output level; writes ignored.
// [RULE_04] Invert bit one makes the output active low.
// [RULE_05] Mode bit one selects pulse frequency, zero fixed duty cycle.
// [RULE_06] Unimplemented register bits read zero and ignore writes.
// [RULE_07] Pulse lasts two to the power of the width field, module periods.
// [RULE_08] Pulse width field matters only in pulse frequency mode.
// [RULE_09] Software keeps pulse width below the accumulator overflow period.
// [RULE_10] Two-bit field picks one of four module clock sources.
// [RULE_11] All implemented register bits reset to zero on any reset.
package oc_pkg;

	localparam int APB_AW = 12;

	// register byte addresses
	localparam logic [11:0] ADDR_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_CLOCK_SELECT = 12'h004;

	// control register fields
	localparam int CTRL_ENABLE_BIT = 7;
	localparam int CTRL_PIN_ENABLE_BIT = 6;
	localparam int CTRL_LEVEL_BIT = 5;
	localparam int CTRL_INVERT_BIT = 4;
	localparam int CTRL_PFM_BIT = 0;
	localparam logic [7:0] CTRL_WRITE_MASK = 8'hd1;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// clock select register fields
	localparam int CLK_PWS_LSB = 5;
	localparam int CLK_PWS_W = 3;
	localparam int CLK_CKS_LSB = 0;
	localparam int CLK_CKS_W = 2;
	localparam logic [7:0] CLK_WRITE_MASK = 8'he3;
	localparam logic [7:0] CLK_RESET = 8'h00;

	// clock source codes
	localparam logic [1:0] CKS_FAST_OSC = 2'h0;
	localparam logic [1:0] CKS_SYSTEM = 2'h1;
	localparam logic [1:0] CKS_LOGIC_CELL = 2'h2;
	localparam logic [1:0] CKS_EXT_PIN = 2'h3;

	// nominal fast internal oscillator rate, for reference
	localparam int FAST_OSC_MHZ = 16;

	localparam int PULSE_CNT_W = 8;

	typedef enum logic [0:0] {
		OC_IDLE,
		OC_PULSE
	} oc_state_e;

	function automatic logic [PULSE_CNT_W-1:0] oc_pulse_len(
		input logic [CLK_PWS_W-1:0] pws
	);
		oc_pulse_len = 8'h01 << pws;
	endfunction : oc_pulse_len

endpackage : oc_pkg

// file: rtl/oc_clk_sel.sv
/*
 * Module clock source selector: turns the chosen source into one-cycle
 * ticks of pclk. Assumes all source inputs are synchronous to pclk and
 * slower than half its rate.
 */
`timescale 1ns/1ns
module oc_clk_sel (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// selection
	input wire logic [1:0] source_select,
	input wire logic module_enable,
	// sources
	input wire logic fast_internal_oscillator,
	input wire logic logic_cell_one_output,
	input wire logic external_clock_pin,
	// module clock tick
	output logic tick_q
);
	import oc_pkg::*;

	logic [2:0] prev_q;
	logic [2:0] prev_d;
	logic tick_d;

	always_comb begin
		prev_d = {external_clock_pin, logic_cell_one_output,
			fast_internal_oscillator};
		tick_d = 1'b0;
		// [RULE_01] no ticks while disabled
		if (module_enable) begin
			// [RULE_10] source by select code
			case (source_select)
				CKS_FAST_OSC: tick_d = fast_internal_oscillator & ~prev_q[0];
				CKS_SYSTEM: tick_d = 1'b1;
				CKS_LOGIC_CELL: tick_d = logic_cell_one_output & ~prev_q[1];
				CKS_EXT_PIN: tick_d = external_clock_pin & ~prev_q[2];
				default: tick_d = 1'b0;
			endcase
		end
	end

	// history keeps sampling while disabled so enabling gives no false edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 3'h0;
			tick_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
			tick_q <= tick_d;
		end
	end

endmodule : oc_clk_sel

// file: rtl/oc_ctrl.sv
/*
 * Oscillator output control: APB register file, clock source selection,
 * fixed duty cycle and pulse frequency output shaping, polarity and pin.
 * Assumes the accumulator outside delivers a one-cycle overflow pulse on
 * pclk, aligned with a module clock tick it received from this block.
 */
`timescale 1ns/1ns
module oc_ctrl (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [oc_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// clock sources
	input wire logic fast_internal_oscillator,
	input wire logic logic_cell_one_output,
	input wire logic external_clock_pin,
	// accumulator side
	input wire logic accumulator_overflow,
	output logic module_tick,
	output logic module_running,
	// output pin
	output logic pin_out,
	output logic pin_oe
);
	import oc_pkg::*;

	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [7:0] clk_q;
	logic [7:0] clk_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;
	logic access;
	logic hit_ctrl;
	logic hit_clk;
	logic commit;
	logic level;

	logic tick;
	oc_state_e state_q;
	oc_state_e state_d;
	logic [PULSE_CNT_W-1:0] cnt_q;
	logic [PULSE_CNT_W-1:0] cnt_d;
	logic out_raw_q;
	logic out_raw_d;
	logic pin_out_q;
	logic pin_out_d;
	logic pin_oe_q;
	logic pin_oe_d;
	logic running_q;
	logic running_d;

	wire en = ctrl_q[CTRL_ENABLE_BIT];
	wire pfm = ctrl_q[CTRL_PFM_BIT];
	wire inv = ctrl_q[CTRL_INVERT_BIT];
	wire [CLK_PWS_W-1:0] pws = clk_q[CLK_PWS_LSB +: CLK_PWS_W];
	wire [CLK_CKS_W-1:0] cks = clk_q[CLK_CKS_LSB +: CLK_CKS_W];
	wire [7:0] wbyte = pwdata[7:0];

	// module output level after polarity
	assign level = out_raw_q ^ inv;

	// ---------------- apb register file ----------------
	always_comb begin
		access = psel & penable & ~pready_q;
		hit_ctrl = (paddr == ADDR_CONTROL);
		hit_clk = (paddr == ADDR_CLOCK_SELECT);
		// writes land at the edge that sees pready high
		commit = psel & penable & pready_q & pwrite;
		pready_d = access;
		pslverr_d = access & ~hit_ctrl & ~hit_clk;
		prdata_d = 32'h0;
		ctrl_d = ctrl_q;
		clk_d = clk_q;
		if (access && !pwrite) begin
			// [RULE_03] live level in status bit
			if (hit_ctrl) begin
				prdata_d[7:0] = ctrl_q & CTRL_WRITE_MASK;
				prdata_d[CTRL_LEVEL_BIT] = level;
			end
			// [RULE_06] reserved bits read zero
			if (hit_clk) begin
				prdata_d[7:0] = clk_q & CLK_WRITE_MASK;
			end
		end
		if (commit) begin
			// [RULE_06] masked writes only
			if (hit_ctrl) begin
				ctrl_d = wbyte & CTRL_WRITE_MASK;
			end
			if (hit_clk) begin
				clk_d = wbyte & CLK_WRITE_MASK;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		// [RULE_11] all fields clear
		if (!presetn) begin
			ctrl_q <= CTRL_RESET;
			clk_q <= CLK_RESET;
			prdata_q <= 32'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			clk_q <= clk_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// ---------------- module clock ----------------
	oc_clk_sel u_clk_sel (
		.pclk(pclk),
		.presetn(presetn),
		.source_select(cks),
		.module_enable(en),
		.fast_internal_oscillator(fast_internal_oscillator),
		.logic_cell_one_output(logic_cell_one_output),
		.external_clock_pin(external_clock_pin),
		.tick_q(tick)
	);

	// ---------------- output shaping ----------------
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		out_raw_d = out_raw_q;
		// [RULE_01] disabled holds output low
		if (!en) begin
			state_d = OC_IDLE;
			cnt_d = '0;
			out_raw_d = 1'b0;
		// [RULE_05] fixed duty cycle toggles
		end else if (!pfm) begin
			// [RULE_08] width field unused here
			state_d = OC_IDLE;
			cnt_d = '0;
			if (accumulator_overflow) begin
				out_raw_d = ~out_raw_q;
			end
		end else begin
			case (state_q)
				OC_IDLE: begin
					out_raw_d = 1'b0;
					// [RULE_07] load pulse length
					if (accumulator_overflow) begin
						state_d = OC_PULSE;
						cnt_d = oc_pulse_len(pws);
						out_raw_d = 1'b1;
					end
				end
				OC_PULSE: begin
					// [RULE_09] overflow during pulse is ignored
					if (tick) begin
						cnt_d = cnt_q - 8'h01;
						if (cnt_q == 8'h01) begin
							state_d = OC_IDLE;
							out_raw_d = 1'b0;
						end
					end
				end
				default: begin
					state_d = OC_IDLE;
					out_raw_d = 1'b0;
				end
			endcase
		end
		// [RULE_04] invert on the pin
		pin_out_d = out_raw_q ^ inv;
		// [RULE_02] pin driven only when allowed
		pin_oe_d = ctrl_q[CTRL_PIN_ENABLE_BIT] & en;
		running_d = en;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= OC_IDLE;
			cnt_q <= '0;
			out_raw_q <= 1'b0;
			pin_out_q <= 1'b0;
			pin_oe_q <= 1'b0;
			running_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			out_raw_q <= out_raw_d;
			pin_out_q <= pin_out_d;
			pin_oe_q <= pin_oe_d;
			running_q <= running_d;
		end
	end

	assign pin_out = pin_out_q;
	assign pin_oe = pin_oe_q;
	assign module_running = running_q;
	assign module_tick = tick;

	// ---------------- assertions ----------------
	AST_DISABLED_LOW: assert property ( // [RULE_01]
		@(posedge pclk) disable iff (!presetn)
		!en |=> !out_raw_q && !tick && !module_running)
		else $error("output or tick active while disabled");

	AST_PIN_OFF: assert property ( // [RULE_02]
		@(posedge pclk) disable iff (!presetn)
		!ctrl_q[CTRL_PIN_ENABLE_BIT] |=> !pin_oe_q)
		else $error("pin driven with pin enable clear");

	AST_STATUS_LEVEL: assert property ( // [RULE_03]
		@(posedge pclk) disable iff (!presetn)
		access && !pwrite && hit_ctrl
		|=> prdata_q[CTRL_LEVEL_BIT] == $past(level))
		else $error("status bit differs from output level");

	AST_PIN_POLARITY: assert property ( // [RULE_04]
		@(posedge pclk) disable iff (!presetn)
		inv |=> pin_out_q != $past(out_raw_q))
		else $error("pin level ignores invert bit");

	AST_FDC_TOGGLE: assert property ( // [RULE_05]
		@(posedge pclk) disable iff (!presetn)
		en && !pfm && accumulator_overflow |=> out_raw_q != $past(out_raw_q))
		else $error("fixed duty output did not toggle on overflow");

	AST_RESERVED_ZERO: assert property ( // [RULE_06]
		@(posedge pclk) disable iff (!presetn)
		pready_q |-> prdata_q[31:8] == 24'h0
			&& (ctrl_q & ~CTRL_WRITE_MASK) == 8'h00
			&& (clk_q & ~CLK_WRITE_MASK) == 8'h00)
		else $error("reserved bits not zero");

	AST_PULSE_START: assert property ( // [RULE_07]
		@(posedge pclk) disable iff (!presetn)
		en && pfm && state_q == OC_IDLE && accumulator_overflow
		|=> out_raw_q && cnt_q == oc_pulse_len($past(pws)))
		else $error("pulse started with wrong length");

	AST_PULSE_END: assert property ( // [RULE_07]
		@(posedge pclk) disable iff (!presetn)
		en && pfm && state_q == OC_PULSE && tick && cnt_q == 8'h01
		|=> !out_raw_q && state_q == OC_IDLE)
		else $error("pulse did not end after its last period");

	AST_FDC_NO_PULSE: assert property ( // [RULE_08]
		@(posedge pclk) disable iff (!presetn)
		en && !pfm |=> state_q == OC_IDLE && cnt_q == 8'h00)
		else $error("pulse logic active in fixed duty mode");

	AST_SYS_TICK: assert property ( // [RULE_10]
		@(posedge pclk) disable iff (!presetn)
		en && cks == CKS_SYSTEM |=> tick)
		else $error("system clock source gave no tick");

	AST_RESET_CLEAR: assert property ( // [RULE_11]
		@(posedge pclk) disable iff (!presetn)
		!$past(presetn) |-> ctrl_q == CTRL_RESET && clk_q == CLK_RESET)
		else $error("registers not clear after reset");

	AST_RUNNING_ON: assert property ( // [RULE_01]
		@(posedge pclk) disable iff (!presetn)
		en |=> module_running)
		else $error("module not running while enabled");

	AST_PIN_ON: assert property ( // [RULE_02]
		@(posedge pclk) disable iff (!presetn)
		en && ctrl_q[CTRL_PIN_ENABLE_BIT] |=> pin_oe_q)
		else $error("pin not driven with both enables set");

	AST_STATUS_READ_ONLY: assert property ( // [RULE_03]
		@(posedge pclk) disable iff (!presetn)
		commit && hit_ctrl |=> !ctrl_q[CTRL_LEVEL_BIT])
		else $error("status bit stored by a write");

	AST_PIN_PLAIN: assert property ( // [RULE_04]
		@(posedge pclk) disable iff (!presetn)
		!inv |=> pin_out_q == $past(out_raw_q))
		else $error("pin inverted with invert bit clear");

	AST_WRITE_MASKED: assert property ( // [RULE_06]
		@(posedge pclk) disable iff (!presetn)
		commit && hit_clk |=> clk_q == ($past(wbyte) & CLK_WRITE_MASK))
		else $error("clock select write not masked");

	AST_FDC_HOLD: assert property ( // [RULE_05]
		@(posedge pclk) disable iff (!presetn)
		en && !pfm && !accumulator_overflow |=> $stable(out_raw_q))
		else $error("fixed duty output moved without overflow");

	AST_PFM_IDLE_LOW: assert property ( // [RULE_05]
		@(posedge pclk) disable iff (!presetn)
		en && pfm && state_q == OC_IDLE && !accumulator_overflow
		|=> !out_raw_q)
		else $error("pulse output high while idle");

	AST_PULSE_HOLD: assert property ( // [RULE_07]
		@(posedge pclk) disable iff (!presetn)
		en && pfm && state_q == OC_PULSE && !(tick && cnt_q == 8'h01)
		|=> out_raw_q && state_q == OC_PULSE)
		else $error("pulse ended early");

	AST_PULSE_COUNT: assert property ( // [RULE_07]
		@(posedge pclk) disable iff (!presetn)
		en && pfm && state_q == OC_PULSE && tick
		|=> cnt_q == $past(cnt_q) - 8'h01)
		else $error("pulse counter missed a module period");

	AST_PULSE_NO_TICK: assert property ( // [RULE_07]
		@(posedge pclk) disable iff (!presetn)
		en && pfm && state_q == OC_PULSE && !tick |=> $stable(cnt_q))
		else $error("pulse counter moved without a module period");

	AST_FAST_TICK: assert property ( // [RULE_10]
		@(posedge pclk) disable iff (!presetn)
		en && cks == CKS_FAST_OSC
		|=> tick == ($past(fast_internal_oscillator)
			&& !$past(fast_internal_oscillator, 2)))
		else $error("fast oscillator edge not turned into a tick");

	AST_CELL_TICK: assert property ( // [RULE_10]
		@(posedge pclk) disable iff (!presetn)
		en && cks == CKS_LOGIC_CELL
		|=> tick == ($past(logic_cell_one_output)
			&& !$past(logic_cell_one_output, 2)))
		else $error("logic cell edge not turned into a tick");

	AST_EXT_TICK: assert property ( // [RULE_10]
		@(posedge pclk) disable iff (!presetn)
		en && cks == CKS_EXT_PIN
		|=> tick == ($past(external_clock_pin)
			&& !$past(external_clock_pin, 2)))
		else $error("external pin edge not turned into a tick");

	AST_PREADY_PULSE: assert property (
		@(posedge pclk) disable iff (!presetn)
		pready_q |=> !pready_q)
		else $error("ready held longer than one cycle");

	AST_UNMAPPED_ERROR: assert property (
		@(posedge pclk) disable iff (!presetn)
		access && !hit_ctrl && !hit_clk |=> pslverr_q && prdata_q == 32'h0)
		else $error("unmapped access not flagged");

endmodule : oc_ctrl

// file: tb/oc_ctrl_bench.sv
/*
 * Self-checking bench for oc_ctrl: APB register access, output shaping,
 * polarity, pin enable and module clock source selection.
 * Assumes oc_pkg constants and a one-wait-state APB slave.
 */
`timescale 1ns/1ns
module oc_ctrl_bench;
	import oc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, err, m_tick, m_run, pin_out, pin_oe;
	logic ovf = 1'b0;
	logic src_fast = 1'b0;
	logic src_cell = 1'b0;
	logic src_ext = 1'b0;
	logic [5:0] cyc = 6'h00;
	int fail_count = 0;
	int n_compared = 0;

	always #5 pclk = ~pclk;

	// sources with periods of 4, 6 and 10 cycles
	always @(posedge pclk) begin
		cyc <= (cyc == 6'h3b) ? 6'h00 : cyc + 6'h01;
		src_fast <= cyc[1];
		src_cell <= (cyc % 6) < 3;
		src_ext <= (cyc % 10) < 5;
	end

	oc_ctrl dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.fast_internal_oscillator(src_fast),
		.logic_cell_one_output(src_cell), .external_clock_pin(src_ext),
		.accumulator_overflow(ovf), .module_tick(m_tick),
		.module_running(m_run), .pin_out(pin_out), .pin_oe(pin_oe)
	);

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fail_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task ovf_pulse;
		@(posedge pclk);
		ovf <= 1'b1;
		@(posedge pclk);
		ovf <= 1'b0;
	endtask : ovf_pulse

	task count_ticks(output int n);
		repeat (10) @(posedge pclk);
		n = 0;
		repeat (60) begin
			@(posedge pclk);
			if (m_tick === 1'b1) n++;
		end
	endtask : count_ticks

	task t_reset;
		apb(1'b0, ADDR_CONTROL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, ADDR_CLOCK_SELECT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h008, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		$display("test reset done");
	endtask : t_reset

	task t_regs;
		apb(1'b1, ADDR_CONTROL, 32'hffffffff);
		apb(1'b0, ADDR_CONTROL, 32'h0);
		chk(rd, 32'h000000f1);
		chk({31'h0, pin_oe}, 32'h1);
		chk({31'h0, pin_out}, 32'h1);
		apb(1'b1, ADDR_CONTROL, 32'h00000040);
		repeat (3) @(posedge pclk);
		chk({30'h0, m_run, pin_oe}, 32'h0);
		apb(1'b1, ADDR_CLOCK_SELECT, 32'hffffffff);
		apb(1'b0, ADDR_CLOCK_SELECT, 32'h0);
		chk(rd, 32'h000000e3);
		$display("test registers done");
	endtask : t_regs

	task t_fixed;
		apb(1'b1, ADDR_CLOCK_SELECT, 32'h00000001);
		apb(1'b1, ADDR_CONTROL, 32'h000000c0);
		ovf_pulse;
		repeat (12) @(posedge pclk);
		#1 chk({31'h0, pin_out}, 32'h1);
		apb(1'b0, ADDR_CONTROL, 32'h0);
		chk(rd, 32'h000000e0);
		ovf_pulse;
		repeat (3) @(posedge pclk);
		#1 chk({31'h0, pin_out}, 32'h0);
		$display("test fixed duty done");
	endtask : t_fixed

	task t_pulse;
		int n;
		apb(1'b1, ADDR_CONTROL, 32'h000000c1);
		for (int w = 0; w < 8; w++) begin
			apb(1'b1, ADDR_CLOCK_SELECT, {24'h0, w[2:0], 5'h01});
			// one overflow, then a long quiet gap
			ovf_pulse;
			n = 0;
			repeat (300) begin
				@(posedge pclk);
				if (pin_out === 1'b1) n++;
			end
			chk(n, 32'h1 << w);
		end
		$display("test pulse width done");
	endtask : t_pulse

	task t_sources;
		int n;
		logic [31:0] exp [4];
		exp = '{32'h0f, 32'h3c, 32'h0a, 32'h06};
		apb(1'b1, ADDR_CONTROL, 32'h00000080);
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, ADDR_CLOCK_SELECT, {30'h0, s[1:0]});
			count_ticks(n);
			chk(n, exp[s]);
		end
		chk({30'h0, m_run, pin_oe}, 32'h2);
		apb(1'b1, ADDR_CONTROL, 32'h0);
		count_ticks(n);
		chk(n, 32'h0);
		$display("test clock sources done");
	endtask : t_sources

	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_regs;
		t_fixed;
		t_pulse;
		t_sources;
		print_verdict;
	end

	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		print_verdict;
	end
endmodule : oc_ctrl_bench
